// ==== design/rbm_readback_mux.sv ====
// readback command mux: decodes read codes and snapshots values
// assumes all value inputs come from logic on pclk (no synchronisers)
//
// Operation
// - read code loads readback words, 2 or 4 bytes
// - values are binary, negatives two's complement
// - rate and timer units assume 16 MHz clock
// - code 30h returns commanded position count
// - code 31h returns encoder position count
// - code 32h returns pulse rate, zero stopped
// - code 33h returns ramp rate, zero stopped
// - constant linear phase returns ramp-up setting
// - codes 34h-37h return hold registers 0-3
// - code 38h returns running timer, zero stopped
// - codes 3Dh-3Fh return mode words one-three
// - mode word addresses read back as zero
// - two-byte codes force high word zero
// - code 40h returns hold register mode word
// - code 41h returns pin setup word one
// - code 42h returns pin setup word two
// - code 43h returns ramp-up rate setting
// - code 44h returns starting pulse rate
// - code 45h returns target pulse rate
// - code 46h returns move length or goal
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "rbm_cfg.svh"

module rbm_readback_mux
    import rbm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [31:0]       commanded_position_count,
    input  wire logic [31:0]       encoder_position_count,
    input  wire logic [31:0]       present_pulse_rate,
    input  wire logic [31:0]       present_ramp_rate,
    input  wire logic [31:0]       general_hold_reg_zero,
    input  wire logic [31:0]       general_hold_reg_one,
    input  wire logic [31:0]       general_hold_reg_two,
    input  wire logic [31:0]       general_hold_reg_three,
    input  wire logic [31:0]       running_timer_now,
    input  wire logic [15:0]       hold_reg_mode_word,
    input  wire logic [15:0]       pin_io_setup_one,
    input  wire logic [15:0]       pin_io_setup_two,
    input  wire logic [31:0]       ramp_up_rate_setting,
    input  wire logic [31:0]       starting_pulse_rate,
    input  wire logic [31:0]       target_pulse_rate,
    input  wire logic [31:0]       move_length_or_goal,
    input  wire logic              motion_stopped,
    input  wire logic              ramp_const_phase,
    input  wire logic              ramp_s_curve,
    output logic [15:0]            mode_word_one,
    output logic [15:0]            mode_word_two,
    output logic [15:0]            mode_word_three,
    output logic [7:0]             last_read_code
);

    // ------------------------------------------------------------------
    // APB slave handshake
    // ------------------------------------------------------------------
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        acc_go;
    logic        wr_go;
    logic        rd_go;
    logic        cmd_take;
    logic        addr_hit;
    logic [7:0]  ofs;

    // one wait state: pready comes from a flop, so the answer is the
    // second access cycle; costs a cycle but keeps prdata registered
    assign acc_go   = psel && penable && pready_reg;
    assign wr_go    = acc_go && pwrite;
    assign rd_go    = acc_go && !pwrite;
    assign ofs      = 8'(paddr);
    assign cmd_take = wr_go && (ofs == `RBM_OFS_CMD);

    // map check for the slave error answer
    always_comb begin
        unique case (ofs)
            `RBM_OFS_CMD, `RBM_OFS_RB_LOW, `RBM_OFS_RB_HIGH,
            `RBM_OFS_MODE_ONE, `RBM_OFS_MODE_TWO,
            `RBM_OFS_MODE_THR: addr_hit = 1'b1;
            default:           addr_hit = 1'b0;
        endcase
    end

    // ready pulses for one cycle per access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= psel && penable && !pready_reg;
            pslverr_reg <= psel && penable && !pready_reg && !addr_hit;
        end
    end

    // ------------------------------------------------------------------
    // mode words: write-only at their addresses
    // ------------------------------------------------------------------
    logic [15:0] mode_one_reg;
    logic [15:0] mode_two_reg;
    logic [15:0] mode_thr_reg;

    // stored here, driven out to the motion logic they configure
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_one_reg <= `RBM_RST_WORD;
            mode_two_reg <= `RBM_RST_WORD;
            mode_thr_reg <= `RBM_RST_WORD;
        end else if (wr_go) begin
            if (ofs == `RBM_OFS_MODE_ONE) mode_one_reg <= pwdata[15:0];
            if (ofs == `RBM_OFS_MODE_TWO) mode_two_reg <= pwdata[15:0];
            if (ofs == `RBM_OFS_MODE_THR) mode_thr_reg <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // read code decode
    // ------------------------------------------------------------------
    logic [7:0]  code;
    logic [31:0] sel_data;
    logic        sel_hit;
    logic        sel_wide;

    assign code = pwdata[`RBM_CODE_MSB:`RBM_CODE_LSB];

    // all inputs already binary / two's complement, passed untouched
    // rate and timer units follow the motion logic's clock scaling
    always_comb begin
        sel_data = 32'h0000_0000;
        sel_hit  = 1'b1;
        sel_wide = 1'b1;
        unique case (code)
            RBM_RD_CMD_POS: sel_data = commanded_position_count;
            RBM_RD_ENC_POS: sel_data = encoder_position_count;
            RBM_RD_RATE:
                sel_data = motion_stopped ? 32'h0000_0000 : present_pulse_rate;
            RBM_RD_RAMP: begin
                if (motion_stopped)
                    sel_data = 32'h0000_0000;
                else if (ramp_const_phase && !ramp_s_curve)
                    sel_data = ramp_up_rate_setting;
                else
                    sel_data = present_ramp_rate;
            end
            RBM_RD_HOLD0: sel_data = general_hold_reg_zero;
            RBM_RD_HOLD1: sel_data = general_hold_reg_one;
            RBM_RD_HOLD2: sel_data = general_hold_reg_two;
            RBM_RD_HOLD3: sel_data = general_hold_reg_three;
            RBM_RD_TIMER:
                sel_data = motion_stopped ? 32'h0000_0000 : running_timer_now;
            RBM_RD_MODE_ONE: begin
                sel_data = {16'h0000, mode_one_reg};
                sel_wide = 1'b0;
            end
            RBM_RD_MODE_TWO: begin
                sel_data = {16'h0000, mode_two_reg};
                sel_wide = 1'b0;
            end
            RBM_RD_MODE_THR: begin
                sel_data = {16'h0000, mode_thr_reg};
                sel_wide = 1'b0;
            end
            RBM_RD_HOLD_MODE: begin
                sel_data = {16'h0000, hold_reg_mode_word};
                sel_wide = 1'b0;
            end
            RBM_RD_PIN_ONE: begin
                sel_data = {16'h0000, pin_io_setup_one};
                sel_wide = 1'b0;
            end
            RBM_RD_PIN_TWO: begin
                sel_data = {16'h0000, pin_io_setup_two};
                sel_wide = 1'b0;
            end
            RBM_RD_RAMP_SET: sel_data = ramp_up_rate_setting;
            RBM_RD_START:    sel_data = starting_pulse_rate;
            RBM_RD_TARGET:   sel_data = target_pulse_rate;
            RBM_RD_MOVE:     sel_data = move_length_or_goal;
            // other codes belong to setting or drive logic elsewhere
            default: sel_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // readback words: snapshot taken on the command write edge
    // ------------------------------------------------------------------
    logic [15:0] rb_low_reg;
    logic [15:0] rb_high_reg;
    logic [7:0]  code_reg;

    // snapshot, not live view: the host sees one coherent 32-bit value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_low_reg  <= `RBM_RST_WORD;
            rb_high_reg <= `RBM_RST_WORD;
            code_reg    <= 8'h00;
        end else if (cmd_take && sel_hit) begin
            rb_low_reg  <= sel_data[15:0];
            rb_high_reg <= sel_wide ? sel_data[31:16] : `RBM_RST_WORD;
            code_reg    <= code;
        end
    end

    // ------------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------------
    // mode word addresses answer zero, never the stored word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && penable && !pready_reg && !pwrite) begin
            unique case (ofs)
                `RBM_OFS_RB_LOW:  prdata_reg <= {16'h0000, rb_low_reg};
                `RBM_OFS_RB_HIGH: prdata_reg <= {16'h0000, rb_high_reg};
                default:          prdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            prdata_reg <= 32'h0000_0000;
        end
    end

    assign prdata          = prdata_reg;
    assign pready          = pready_reg;
    assign pslverr         = pslverr_reg;
    assign mode_word_one   = mode_one_reg;
    assign mode_word_two   = mode_two_reg;
    assign mode_word_three = mode_thr_reg;
    assign last_read_code  = code_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_cmd_pos_load: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h30
        |=> {rb_high_reg, rb_low_reg} == $past(commanded_position_count))
        else $error("commanded position not loaded");

    a_enc_pos_load: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h31
        |=> {rb_high_reg, rb_low_reg} == $past(encoder_position_count))
        else $error("encoder position not loaded");

    a_rate_stopped: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h32 && motion_stopped
        |=> rb_low_reg == 16'h0000 && rb_high_reg == 16'h0000)
        else $error("pulse rate not zero while stopped");

    a_ramp_stopped: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h33 && motion_stopped
        |=> {rb_high_reg, rb_low_reg} == 32'h0000_0000)
        else $error("ramp rate not zero while stopped");

    a_ramp_const: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h33 && !motion_stopped && ramp_const_phase && !ramp_s_curve
        |=> {rb_high_reg, rb_low_reg} == $past(ramp_up_rate_setting))
        else $error("constant phase ramp rate wrong");

    a_hold_pick: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h37
        |=> {rb_high_reg, rb_low_reg} == $past(general_hold_reg_three))
        else $error("hold register three not loaded");

    a_timer_stopped: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h38 && motion_stopped
        |=> {rb_high_reg, rb_low_reg} == 32'h0000_0000)
        else $error("timer not zero while stopped");

    a_mode_word: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h3E |=> rb_low_reg == $past(mode_two_reg))
        else $error("mode word two not loaded");

    a_wo_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && !pready_reg && ofs == `RBM_OFS_MODE_ONE
        |=> pready_reg && prdata_reg == 32'h0000_0000)
        else $error("write-only mode word visible on read");

    a_narrow_high: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code >= 8'h3D && code <= 8'h42 |=> rb_high_reg == 16'h0000)
        else $error("high word not cleared for narrow code");

    a_hold_stable: assert property (@(posedge pclk) disable iff (!presetn)
        !cmd_take |=> $stable(rb_low_reg) && $stable(rb_high_reg))
        else $error("readback changed without a read code");

    a_ready_time: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg)
        else $error("ready not a single cycle after access");

    a_load_latency: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && sel_hit |=> code_reg == $past(code))
        else $error("read code not taken in one cycle");

    a_code_refused: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && !sel_hit |=> $stable(rb_low_reg) && $stable(rb_high_reg))
        else $error("unknown read code changed the readback");

    a_rate_live: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h32 && !motion_stopped
        |=> {rb_high_reg, rb_low_reg} == $past(present_pulse_rate))
        else $error("pulse rate not loaded while moving");

    a_ramp_live: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h33 && !motion_stopped && !ramp_const_phase
        |=> {rb_high_reg, rb_low_reg} == $past(present_ramp_rate))
        else $error("ramp rate not loaded while ramping");

    a_hold_zero: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h34
        |=> {rb_high_reg, rb_low_reg} == $past(general_hold_reg_zero))
        else $error("hold register zero not loaded");

    a_timer_live: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h38 && !motion_stopped
        |=> {rb_high_reg, rb_low_reg} == $past(running_timer_now))
        else $error("running timer not loaded while moving");

    a_hold_mode: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h40
        |=> rb_low_reg == $past(hold_reg_mode_word) && rb_high_reg == 16'h0000)
        else $error("hold register mode word not loaded");

    a_pin_two: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h42
        |=> rb_low_reg == $past(pin_io_setup_two) && rb_high_reg == 16'h0000)
        else $error("pin setup word two not loaded");

    a_ramp_set: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h43
        |=> {rb_high_reg, rb_low_reg} == $past(ramp_up_rate_setting))
        else $error("ramp-up rate setting not loaded");

    a_move_len: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_take && code == 8'h46
        |=> {rb_high_reg, rb_low_reg} == $past(move_length_or_goal))
        else $error("move length not loaded");

endmodule

// ==== design/rbm_cfg.svh ====
// register offsets, reset values and timing counts of the readback mux
// assumes a 100 MHz pclk and a 32-bit APB register bus
`ifndef RBM_CFG_SVH
`define RBM_CFG_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define RBM_OFS_CMD       8'h00
`define RBM_OFS_RB_LOW    8'h04
`define RBM_OFS_RB_HIGH   8'h08
`define RBM_OFS_MODE_ONE  8'h0C
`define RBM_OFS_MODE_TWO  8'h10
`define RBM_OFS_MODE_THR  8'h14

// ------------------------------------------------------------------
// reset values and field layout
// ------------------------------------------------------------------
`define RBM_RST_WORD      16'h0000
`define RBM_CODE_LSB      0
`define RBM_CODE_MSB      7

// ------------------------------------------------------------------
// timing: command access time and the clock it is counted on
// ------------------------------------------------------------------
`define RBM_ACCESS_NS     125
`define RBM_CLK_MHZ       100
// rounded up: a truncated count would wait less than the access time
`define RBM_ACCESS_CYC    ((`RBM_ACCESS_NS * `RBM_CLK_MHZ + 999) / 1000)

`endif

// ==== design/rbm_pkg.sv ====
// types shared by the readback mux: the read codes it understands
// assumes nothing beyond a SystemVerilog compiler
package rbm_pkg;

    // read codes accepted on the command word port
    typedef enum logic [7:0] {
        RBM_RD_CMD_POS   = 8'h30,
        RBM_RD_ENC_POS   = 8'h31,
        RBM_RD_RATE      = 8'h32,
        RBM_RD_RAMP      = 8'h33,
        RBM_RD_HOLD0     = 8'h34,
        RBM_RD_HOLD1     = 8'h35,
        RBM_RD_HOLD2     = 8'h36,
        RBM_RD_HOLD3     = 8'h37,
        RBM_RD_TIMER     = 8'h38,
        RBM_RD_MODE_ONE  = 8'h3D,
        RBM_RD_MODE_TWO  = 8'h3E,
        RBM_RD_MODE_THR  = 8'h3F,
        RBM_RD_HOLD_MODE = 8'h40,
        RBM_RD_PIN_ONE   = 8'h41,
        RBM_RD_PIN_TWO   = 8'h42,
        RBM_RD_RAMP_SET  = 8'h43,
        RBM_RD_START     = 8'h44,
        RBM_RD_TARGET    = 8'h45,
        RBM_RD_MOVE      = 8'h46
    } rbm_code_t;

endpackage

// ==== bench/rbm_host_model.sv ====
// host model: an apb master standing in for the processor
// assumes pclk from the bench; the slave answers in its own time
`timescale 1ns/1ps
`include "rbm_cfg.svh"

module rbm_host_model (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    // bus idle at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // one transfer, held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        penable <= 1'b0;
    endtask

    // drop psel for a cycle; keeps back-to-back reads legal
    task automatic idle();
        psel <= 1'b0;
        @(posedge pclk);
    endtask

    // code write, access-time wait, then both words back to back
    task automatic cmd_read(input logic [7:0] code, output logic [31:0] lo,
                            output logic [31:0] hi);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, `RBM_OFS_CMD, {24'h00_0000, code}, r, e);
        idle();
        repeat (`RBM_ACCESS_CYC) @(posedge pclk); // wait out access time
        xfer(1'b0, `RBM_OFS_RB_LOW, 32'h0000_0000, lo, e);
        xfer(1'b0, `RBM_OFS_RB_HIGH, 32'h0000_0000, hi, e);
        idle();
    endtask
endmodule

// ==== bench/tb.sv ====
// testbench of the readback mux: scenario tasks, host model as master
// assumes the mux answers apb with its own pready; 100 MHz pclk
`timescale 1ns/1ps
`include "rbm_cfg.svh"

module tb;
    import rbm_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, last_code;
    logic [31:0] pwdata, prdata;
    logic [31:0] v [0:15];
    logic        stopped, const_ph, s_curve;
    logic [15:0] mw [0:2];
    int          miscompares, checks_done, cycles;

    rbm_readback_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .commanded_position_count(v[0]), .encoder_position_count(v[1]),
        .present_pulse_rate(v[2]), .present_ramp_rate(v[3]), .general_hold_reg_zero(v[4]),
        .general_hold_reg_one(v[5]), .general_hold_reg_two(v[6]),
        .general_hold_reg_three(v[7]), .running_timer_now(v[8]),
        .hold_reg_mode_word(v[9][15:0]), .pin_io_setup_one(v[10][15:0]),
        .pin_io_setup_two(v[11][15:0]), .ramp_up_rate_setting(v[12]),
        .starting_pulse_rate(v[13]), .target_pulse_rate(v[14]), .move_length_or_goal(v[15]),
        .motion_stopped(stopped), .ramp_const_phase(const_ph), .ramp_s_curve(s_curve),
        .mode_word_one(mw[0]), .mode_word_two(mw[1]), .mode_word_three(mw[2]),
        .last_read_code(last_code));

    rbm_host_model host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // --------------------------------------------------------------
    // clock, timeout and closing report
    // --------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // a hang ends the run; whole run needs roughly 630 cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    // issue a code, then both halves of the snapshot must match
    task automatic expect_code(input logic [7:0] c, input logic [31:0] exp);
        logic [31:0] lo, hi;
        host.cmd_read(c, lo, hi);
        chk(lo, {16'h0000, exp[15:0]});  // low half
        chk(hi, {16'h0000, exp[31:16]}); // high half
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        chk({24'h00_0000, last_code}, 32'h0000_0000); // cleared code
        chk({16'h0000, mw[0]}, 32'h0000_0000);        // cleared mode word
        host.xfer(1'b0, `RBM_OFS_RB_HIGH, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0000);                        // empty snapshot
        chk({31'h0, e}, 32'h0000_0000);               // mapped offset no error
        host.idle();
        $display("test reset done");
    endtask

    // all four-byte codes with signed values, then snapshot hold
    task automatic t_four();
        logic [31:0] old, r;
        logic        e;
        for (int i = 0; i < 9; i++) begin
            expect_code(8'h30 + 8'(i), v[i]);
        end
        for (int i = 0; i < 4; i++) begin
            expect_code(8'h43 + 8'(i), v[12 + i]);
        end
        // change the source of the last code taken (46h) under the snapshot
        old = v[15];
        v[15] <= ~old;
        host.xfer(1'b0, `RBM_OFS_RB_LOW, 32'h0000_0000, r, e);
        chk(r, {16'h0000, old[15:0]});  // stale source kept
        host.xfer(1'b0, `RBM_OFS_RB_HIGH, 32'h0000_0000, r, e);
        chk(r, {16'h0000, old[31:16]}); // stale source kept
        host.idle();
        expect_code(8'h39, old);        // unknown code loads nothing
        $display("test four-byte done");
    endtask

    // live values read zero when stopped; linear cruise gives setting
    task automatic t_live();
        stopped <= 1'b1;
        s_curve <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            expect_code((i == 2) ? 8'h38 : 8'h32 + 8'(i), 32'h0000_0000);
        end
        stopped  <= 1'b0;
        s_curve  <= 1'b0;
        const_ph <= 1'b1;
        expect_code(8'h33, v[12]); // constant linear phase
        const_ph <= 1'b0;
        $display("test live done");
    endtask

    // write-only mode words, two-byte codes, unmapped access
    task automatic t_two();
        logic [31:0] r;
        logic        e;
        logic [15:0] m;
        for (int i = 0; i < 3; i++) begin
            m = 16'h8421 ^ 16'(i * 3);
            host.xfer(1'b1, `RBM_OFS_MODE_ONE + 8'(4 * i), {16'hFFFF, m}, r, e);
            host.xfer(1'b0, `RBM_OFS_MODE_ONE + 8'(4 * i), 32'h0000_0000, r, e);
            host.idle();
            chk(r, 32'h0000_0000);          // setting hidden from bus
            chk({16'h0000, mw[i]}, {16'h0000, m}); // stored word
            expect_code(8'h3D + 8'(i), {16'h0000, m});
            expect_code(8'h40 + 8'(i), {16'h0000, v[9 + i][15:0]});
        end
        chk({24'h00_0000, last_code}, 32'h0000_0042); // last accepted code
        host.xfer(1'b0, 8'h18, 32'h0000_0000, r, e);
        host.idle();
        chk({31'h0, e}, 32'h0000_0001);               // unmapped offset flagged
        $display("test two-byte done");
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        presetn     = 1'b0;
        stopped     = 1'b0;
        const_ph    = 1'b0;
        s_curve     = 1'b0;
        miscompares = 0;
        checks_done = 0;
        cycles      = 0;
        for (int i = 0; i < 16; i++) begin
            v[i] = 32'hF00D_0000 ^ (32'h1111_1111 * 32'(i));
        end
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_four();
        t_live();
        t_two();
        tally_and_finish();
    end
endmodule
